/* cct_cfg.svh */
// cct_cfg.svh: offsets, field positions, reset values and mode codes of the capture block
// assumes: included by bare name from the package and the design modules
`ifndef CCT_CFG_SVH
`define CCT_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets (word aligned, data in bits 7:0)
// ----------------------------------------------------------------
`define CCT_OFS_TSEL_LOW   8'h00
`define CCT_OFS_TSEL_HIGH  8'h04
`define CCT_OFS_OPEN_DRAIN 8'h08
`define CCT_OFS_FLAG       8'h0c
`define CCT_OFS_ENABLE     8'h10
`define CCT_OFS_CHAN_BASE  8'h20
`define CCT_CHAN_STRIDE    8'h10
`define CCT_SUB_CONTROL    2'h0
`define CCT_SUB_LOW        2'h1
`define CCT_SUB_HIGH       2'h2

// ----------------------------------------------------------------
// field positions and writable masks
// ----------------------------------------------------------------
`define CCT_NCHAN          7
`define CCT_TSEL_LOW_MASK  8'hd7
`define CCT_TSEL_HIGH_MASK 8'h17
`define CCT_OD_MASK        8'hfe
`define CCT_FLAG_MASK      8'hfe
`define CCT_CTRL_MASK      8'h3f
`define CCT_C4_POS         0
`define CCT_C5_POS         2
`define CCT_C6_POS         4
`define CCT_C7_POS         6
`define CCT_C8_POS         0
`define CCT_C9_POS         2
`define CCT_C10_POS        4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CCT_RST_BYTE       8'h00
`define CCT_RST_CTRL       6'h00
`define CCT_RST_CAPTURE    16'h0000

// ----------------------------------------------------------------
// mode field codes
// ----------------------------------------------------------------
`define CCT_MODE_OFF       4'h0
`define CCT_MODE_CMP_TOG   4'h2
`define CCT_CAP_CLASS      2'h1
`define CCT_CAP_FALL       2'h0
`define CCT_CAP_RISE       2'h1
`define CCT_CAP_DIV4       2'h2
`define CCT_CAP_DIV16      2'h3
`define CCT_DIV4_LAST      2'h3
`define CCT_DIV16_LAST     4'hf

`endif

/* cct_pkg.sv */
// cct_pkg.sv: types shared by the capture block and its bench
// assumes: cct_cfg.svh holds the numeric constants
package cct_pkg;
  `include "cct_cfg.svh"

  // ----------------------------------------------------------------
  // timer resources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CCT_TIMER_ONE, CCT_TIMER_THREE, CCT_TIMER_FIVE} cct_cc_tmr_t;
  typedef enum logic [1:0] {CCT_TMR2, CCT_TMR4, CCT_TMR6, CCT_TMR8} cct_pwm_tmr_t;

  typedef struct packed {
    cct_cc_tmr_t  cc;
    cct_pwm_tmr_t pwm;
  } cct_tsel_t;

  // ----------------------------------------------------------------
  // wishbone carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } cct_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cct_wb_rsp_t;
endpackage

/* cct_capture_chan.sv */
// cct_capture_chan.sv: one channel's pin synchroniser, edge detect and capture prescaler
// assumes: pin_i is asynchronous; mode_i and timer_ok_i come from the clk_i domain
`timescale 1ns/1ns
`include "cct_cfg.svh"
module cct_capture_chan (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // channel
  input  wire logic       pin_i,
  input  wire logic [3:0] mode_i,
  input  wire logic       timer_ok_i,
  output logic            capture_o
);
  import cct_pkg::*;

  logic [2:0] sync_r, sync_nxt;
  logic       level_r, level_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic       cap_r, cap_nxt;
  logic       agree, rise, fall, hit;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    sync_nxt  = {sync_r[1:0], pin_i};                       // RULE_23
    agree     = (sync_r[1] == sync_r[2]);
    rise      = agree & sync_r[2] & ~level_r;
    fall      = agree & ~sync_r[2] & level_r;
    level_nxt = agree ? sync_r[2] : level_r;
    cnt_nxt   = cnt_r;
    hit       = 1'b0;
    if (mode_i[3:2] != `CCT_CAP_CLASS) begin
      cnt_nxt = 4'h0;                                        // RULE_18 RULE_21
    end else begin
      // switching prescale leaves the count, so a partial count may fire early
      case (mode_i[1:0])                                     // RULE_11 RULE_12 RULE_19
        `CCT_CAP_FALL: hit = fall;
        `CCT_CAP_RISE: hit = rise;
        `CCT_CAP_DIV4: begin
          if (rise) begin
            hit     = (cnt_r[1:0] == `CCT_DIV4_LAST);
            cnt_nxt = hit ? 4'h0 : cnt_r + 4'h1;
          end
        end
        `CCT_CAP_DIV16: begin
          if (rise) begin
            hit     = (cnt_r == `CCT_DIV16_LAST);
            cnt_nxt = hit ? 4'h0 : cnt_r + 4'h1;
          end
        end
        default: hit = 1'b0;
      endcase
    end
    cap_nxt = hit & timer_ok_i;                              // RULE_16
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r  <= 3'h0;
      level_r <= 1'b0;
      cnt_r   <= 4'h0;                                       // RULE_18
      cap_r   <= 1'b0;
    end else if (ce_i) begin
      sync_r  <= sync_nxt;
      level_r <= level_nxt;
      cnt_r   <= cnt_nxt;
      cap_r   <= cap_nxt;
    end
  end

  assign capture_o = cap_r;
endmodule

/* cct_capture_top.sv */
// cct_capture_top.sv: seven capture channels, timer selection and open-drain control
// assumes: classic wishbone master on clk_i; timer counts come from clk_i logic
`timescale 1ns/1ns
`include "cct_cfg.svh"
// Function
// RULE_01 - capture/compare counts timer one, three or five; pwm uses two/four/six/eight
// RULE_02 - all seven channels run together and may share one timer
// RULE_03 - channel 4 select: 00 t1/t2, 01 t3/t4, 10 t3/t6, 11 reserved
// RULE_04 - channel 5: 0 t1/t2, 1 t5/t4; channel 6: 0 t1/t2, 1 t5/t2
// RULE_05 - channel 7: 00 t1/t2, 01 t5/t4, 10 t5/t6, 11 t5/t8
// RULE_06 - channel 8: 00 t1/t2, 01 t5/t4, 10 t5/t6; small part capture on t1
// RULE_07 - channel 9: 0 t1/t2, 1 t5/t4; channel 10: 0 t1/t2, 1 t5/t2
// RULE_08 - software never writes code 11 into channel 4 or 8 select
// RULE_09 - open-drain bit per channel turns its compare/pwm driver open-drain
// RULE_10 - a capture event copies the selected 16-bit timer into the data pair
// RULE_11 - event is falling, rising, every 4th or every 16th rising edge
// RULE_12 - mode 0100 fall, 0101 rise, 0110 fourth rise, 0111 sixteenth rise
// RULE_13 - each capture sets the channel flag; only software clears it
// RULE_14 - a new capture overwrites an unread earlier value
// RULE_15 - pin should be input; own port drive still counts as an event
// RULE_16 - no capture while the selected timer is in asynchronous counter mode
// RULE_17 - changing capture mode may set the flag falsely; software clears it
// RULE_18 - prescale counter cleared when off, not capturing, or in reset
// RULE_19 - changing prescale directly keeps the counter; first capture may be partial
// RULE_20 - software turns the channel off before writing a new prescale
// RULE_21 - mode 0000 disables the channel and returns it to reset state
// RULE_22 - data register is a readable, writable low byte and high byte
// RULE_23 - pin is synchronised before edge detect, one event per edge
module cct_capture_top #(
  parameter bit SMALL_MEM = 1'b0
) (
  // clock, reset, enable
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  // register bus
  input  wire cct_pkg::cct_wb_req_t              wb_req_i,
  output cct_pkg::cct_wb_rsp_t                   wb_rsp_o,
  // timers
  input  wire logic [15:0]                       timer_one_i,
  input  wire logic [15:0]                       timer_three_i,
  input  wire logic [15:0]                       timer_five_i,
  input  wire logic [2:0]                        timer_async_i,
  // channel pins and outputs
  input  wire logic [`CCT_NCHAN-1:0]             pin_i,
  output logic      [`CCT_NCHAN-1:0]             open_drain_o,
  output logic      [`CCT_NCHAN-1:0]             event_req_o,
  output cct_pkg::cct_tsel_t [`CCT_NCHAN-1:0]    tsel_o
);
  import cct_pkg::*;

  localparam int NCH = `CCT_NCHAN;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  tsel_low_r, tsel_low_nxt;
  logic [7:0]  tsel_high_r, tsel_high_nxt;
  logic [7:0]  od_r, od_nxt;
  logic [7:0]  flag_r, flag_nxt;
  logic [7:0]  ien_r, ien_nxt;
  logic [5:0]  ctrl_r [NCH];
  logic [5:0]  ctrl_nxt [NCH];
  logic [15:0] cap_r [NCH];
  logic [15:0] cap_nxt [NCH];
  cct_wb_rsp_t rsp_r, rsp_nxt;
  logic [NCH-1:0] od_out_r, od_out_nxt;
  logic [NCH-1:0] req_r, req_nxt;
  cct_tsel_t [NCH-1:0] tsel_r, tsel_nxt;

  logic [NCH-1:0] capture;
  logic [NCH-1:0] timer_ok;
  cct_tsel_t      chan_tsel [NCH];
  logic [15:0]    chan_timer [NCH];
  logic [5:0]     word_idx;
  logic           wr_en;
  logic [7:0]     wr_byte;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] sel_code(input int ch, input logic [7:0] lo,
                                          input logic [7:0] hi);
    case (ch)
      0:       sel_code = lo[`CCT_C4_POS +: 2];
      1:       sel_code = {1'b0, lo[`CCT_C5_POS]};
      2:       sel_code = {1'b0, lo[`CCT_C6_POS]};
      3:       sel_code = lo[`CCT_C7_POS +: 2];
      4:       sel_code = hi[`CCT_C8_POS +: 2];
      5:       sel_code = {1'b0, hi[`CCT_C9_POS]};
      6:       sel_code = {1'b0, hi[`CCT_C10_POS]};
      default: sel_code = 2'h0;
    endcase
  endfunction

  // reserved codes fall back to timer one/two
  function automatic cct_tsel_t decode(input int ch, input logic [1:0] c);
    cct_tsel_t t;
    t.cc  = CCT_TIMER_ONE;
    t.pwm = CCT_TMR2;
    case (ch)
      0: begin                                                // RULE_03 RULE_08
        if (c == 2'h1) t = '{CCT_TIMER_THREE, CCT_TMR4};
        else if (c == 2'h2) t = '{CCT_TIMER_THREE, CCT_TMR6};
      end
      1, 5: begin                                             // RULE_04 RULE_07
        if (c[0]) t = '{CCT_TIMER_FIVE, CCT_TMR4};
      end
      2, 6: begin                                             // RULE_04 RULE_07
        if (c[0]) t = '{CCT_TIMER_FIVE, CCT_TMR2};
      end
      3: begin                                                // RULE_05
        case (c)
          2'h1:    t = '{CCT_TIMER_FIVE, CCT_TMR4};
          2'h2:    t = '{CCT_TIMER_FIVE, CCT_TMR6};
          2'h3:    t = '{CCT_TIMER_FIVE, CCT_TMR8};
          default: t = '{CCT_TIMER_ONE, CCT_TMR2};
        endcase
      end
      4: begin                                                // RULE_06 RULE_08
        if (c == 2'h1) t = '{CCT_TIMER_FIVE, CCT_TMR4};
        else if (c == 2'h2) t = '{CCT_TIMER_FIVE, CCT_TMR6};
        if (SMALL_MEM) t.cc = CCT_TIMER_ONE;
      end
      default: t = '{CCT_TIMER_ONE, CCT_TMR2};
    endcase
    return t;
  endfunction

  function automatic logic is_output_mode(input logic [3:0] m);
    return (m == `CCT_MODE_CMP_TOG) || m[3];
  endfunction

  // ----------------------------------------------------------------
  // timer selection and channels
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < NCH; k++) begin                       // RULE_02
      chan_tsel[k] = decode(k, sel_code(k, tsel_low_r, tsel_high_r));
      case (chan_tsel[k].cc)                                  // RULE_01
        CCT_TIMER_THREE: begin
          chan_timer[k] = timer_three_i;
          timer_ok[k]   = ~timer_async_i[1];                  // RULE_16
        end
        CCT_TIMER_FIVE: begin
          chan_timer[k] = timer_five_i;
          timer_ok[k]   = ~timer_async_i[2];
        end
        default: begin
          chan_timer[k] = timer_one_i;
          timer_ok[k]   = ~timer_async_i[0];
        end
      endcase
    end
  end

  // own port drive on the pin is seen here like any outside edge
  for (genvar g = 0; g < NCH; g++) begin : g_chan             // RULE_15
    cct_capture_chan u_chan (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .pin_i      (pin_i[g]),
      .mode_i     (ctrl_r[g][3:0]),
      .timer_ok_i (timer_ok[g]),
      .capture_o  (capture[g])
    );
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // a write lands on the edge after ack is presented, where the master samples it
  assign word_idx = wb_req_i.adr[7:2];
  assign wr_byte  = wb_req_i.dat[7:0];
  assign wr_en    = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & rsp_r.ack & wb_req_i.sel[0];

  function automatic logic chan_hit(input logic [5:0] wi, input int ch,
                                    input logic [1:0] sub);
    logic [7:0] a;
    a = `CCT_OFS_CHAN_BASE + 8'(ch) * `CCT_CHAN_STRIDE + {4'h0, sub, 2'h0};
    return wi == a[7:2];
  endfunction

  function automatic logic reg_hit(input logic [5:0] wi, input logic [7:0] ofs);
    return wi == ofs[7:2];
  endfunction

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    tsel_low_nxt  = tsel_low_r;
    tsel_high_nxt = tsel_high_r;
    od_nxt        = od_r;
    ien_nxt       = ien_r;
    flag_nxt      = flag_r;
    rsp_nxt.ack   = wb_req_i.cyc & wb_req_i.stb & ~rsp_r.ack;
    rsp_nxt.dat   = 32'h0;
    if (wr_en && reg_hit(word_idx, `CCT_OFS_TSEL_LOW))
      tsel_low_nxt = wr_byte & `CCT_TSEL_LOW_MASK;
    if (wr_en && reg_hit(word_idx, `CCT_OFS_TSEL_HIGH))
      tsel_high_nxt = wr_byte & `CCT_TSEL_HIGH_MASK;
    if (wr_en && reg_hit(word_idx, `CCT_OFS_OPEN_DRAIN))
      od_nxt = wr_byte & `CCT_OD_MASK;
    if (wr_en && reg_hit(word_idx, `CCT_OFS_ENABLE))
      ien_nxt = wr_byte & `CCT_FLAG_MASK;
    if (wr_en && reg_hit(word_idx, `CCT_OFS_FLAG))
      flag_nxt = wr_byte & `CCT_FLAG_MASK;
    // hardware set wins over a software clear in the same cycle
    flag_nxt = flag_nxt | {capture, 1'b0};                   // RULE_13 RULE_17
    for (int k = 0; k < NCH; k++) begin
      ctrl_nxt[k] = ctrl_r[k];
      cap_nxt[k]  = cap_r[k];
      if (wr_en && chan_hit(word_idx, k, `CCT_SUB_CONTROL))
        ctrl_nxt[k] = wr_byte[5:0];                           // RULE_20 RULE_21
      if (wr_en && chan_hit(word_idx, k, `CCT_SUB_LOW))
        cap_nxt[k][7:0] = wr_byte;                            // RULE_22
      if (wr_en && chan_hit(word_idx, k, `CCT_SUB_HIGH))
        cap_nxt[k][15:8] = wr_byte;                           // RULE_22
      if (capture[k])
        cap_nxt[k] = chan_timer[k];                           // RULE_10 RULE_14
    end
    // read data
    if (rsp_nxt.ack && !wb_req_i.we) begin
      if (reg_hit(word_idx, `CCT_OFS_TSEL_LOW))   rsp_nxt.dat[7:0] = tsel_low_r;
      if (reg_hit(word_idx, `CCT_OFS_TSEL_HIGH))  rsp_nxt.dat[7:0] = tsel_high_r;
      if (reg_hit(word_idx, `CCT_OFS_OPEN_DRAIN)) rsp_nxt.dat[7:0] = od_r;
      if (reg_hit(word_idx, `CCT_OFS_FLAG))       rsp_nxt.dat[7:0] = flag_r;
      if (reg_hit(word_idx, `CCT_OFS_ENABLE))     rsp_nxt.dat[7:0] = ien_r;
      for (int k = 0; k < NCH; k++) begin
        if (chan_hit(word_idx, k, `CCT_SUB_CONTROL)) rsp_nxt.dat[5:0] = ctrl_r[k];
        if (chan_hit(word_idx, k, `CCT_SUB_LOW))     rsp_nxt.dat[7:0] = cap_r[k][7:0];
        if (chan_hit(word_idx, k, `CCT_SUB_HIGH))    rsp_nxt.dat[7:0] = cap_r[k][15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // output next state
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      od_out_nxt[k] = od_r[k+1] & is_output_mode(ctrl_r[k][3:0]);  // RULE_09
      req_nxt[k]    = flag_r[k+1] & ien_r[k+1];
      tsel_nxt[k]   = chan_tsel[k];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tsel_low_r  <= `CCT_RST_BYTE;
      tsel_high_r <= `CCT_RST_BYTE;
      od_r        <= `CCT_RST_BYTE;
      flag_r      <= `CCT_RST_BYTE;
      ien_r       <= `CCT_RST_BYTE;
      rsp_r       <= '0;
      od_out_r    <= '0;
      req_r       <= '0;
      tsel_r      <= '0;
      for (int k = 0; k < NCH; k++) begin
        ctrl_r[k] <= `CCT_RST_CTRL;
        cap_r[k]  <= `CCT_RST_CAPTURE;
      end
    end else if (ce_i) begin
      tsel_low_r  <= tsel_low_nxt;
      tsel_high_r <= tsel_high_nxt;
      od_r        <= od_nxt;
      flag_r      <= flag_nxt;
      ien_r       <= ien_nxt;
      rsp_r       <= rsp_nxt;
      od_out_r    <= od_out_nxt;
      req_r       <= req_nxt;
      tsel_r      <= tsel_nxt;
      for (int k = 0; k < NCH; k++) begin
        ctrl_r[k] <= ctrl_nxt[k];
        cap_r[k]  <= cap_nxt[k];
      end
    end
  end

  assign wb_rsp_o     = rsp_r;
  assign open_drain_o = od_out_r;
  assign event_req_o  = req_r;
  assign tsel_o       = tsel_r;
endmodule

/* cct_capture_top_chk.sv */
// cct_capture_top_chk.sv: port assertions for the capture block
// assumes: classic wishbone master dropping cyc/stb a cycle after ack
`timescale 1ns/1ns
`include "cct_cfg.svh"
module cct_capture_top_chk #(
  parameter bit SMALL_MEM = 1'b0
) (
  // clock, reset, enable
  input wire logic                              clk_i,
  input wire logic                              rst_i,
  input wire logic                              ce_i,
  // register bus
  input wire cct_pkg::cct_wb_req_t              wb_req_i,
  input wire cct_pkg::cct_wb_rsp_t              wb_rsp_o,
  // timers
  input wire logic [15:0]                       timer_one_i,
  input wire logic [15:0]                       timer_three_i,
  input wire logic [15:0]                       timer_five_i,
  input wire logic [2:0]                        timer_async_i,
  // pins and outputs
  input wire logic [`CCT_NCHAN-1:0]             pin_i,
  input wire logic [`CCT_NCHAN-1:0]             open_drain_o,
  input wire logic [`CCT_NCHAN-1:0]             event_req_o,
  input wire cct_pkg::cct_tsel_t [`CCT_NCHAN-1:0] tsel_o
);
  import cct_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req_w;
  logic wr_ack;
  assign req_w  = wb_req_i.cyc && wb_req_i.stb;
  assign wr_ack = wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel[0];
  // ----------------------------------------------------------------
  // expected timer pair per channel and select code
  // ----------------------------------------------------------------
  function automatic logic [3:0] ts(input int k, input logic [1:0] c);
    cct_cc_tmr_t  cc;
    cct_pwm_tmr_t pw;
    cc = (c == 2'h0 || (SMALL_MEM && k == 4)) ? CCT_TIMER_ONE : (k == 0 ? CCT_TIMER_THREE : CCT_TIMER_FIVE);
    pw = (k == 2 || k == 6) ? CCT_TMR2 : cct_pwm_tmr_t'(c);
    return {cc, pw};
  endfunction
  property p_ack_next;
    req_w && ce_i && !wb_rsp_o.ack |=> wb_rsp_o.ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_once;
    wb_rsp_o.ack && ce_i |=> !wb_rsp_o.ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_cause;
    $rose(wb_rsp_o.ack) |-> $past(req_w);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_rd_upper;
    wb_rsp_o.ack && !wb_req_i.we |-> wb_rsp_o.dat[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read upper bits set");
  property p_wr_dat;
    wb_rsp_o.ack && wb_req_i.we |-> wb_rsp_o.dat == 32'h00000000;
  endproperty
  a_wr_dat: assert property (p_wr_dat) else $error("write ack carries data");
  property p_reset_quiet;
    $fell(rst_i) |-> !wb_rsp_o.ack && open_drain_o == '0 && event_req_o == '0 && tsel_o == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs after reset");
  property p_tsel_low;
    wr_ack && wb_req_i.adr == `CCT_OFS_TSEL_LOW |-> ##2
      tsel_o[0] == ts(0, $past(wb_req_i.dat[1:0], 2)) &&
      tsel_o[3] == ts(3, $past(wb_req_i.dat[7:6], 2));
  endproperty
  a_tsel_low: assert property (p_tsel_low) else $error("low select decode");
  property p_tsel_high;
    wr_ack && wb_req_i.adr == `CCT_OFS_TSEL_HIGH |-> ##2
      tsel_o[4] == ts(4, $past(wb_req_i.dat[1:0], 2)) &&
      tsel_o[6] == ts(6, {1'b0, $past(wb_req_i.dat[4], 2)});
  endproperty
  a_tsel_high: assert property (p_tsel_high) else $error("high select decode");
  c_read: cover property (wb_rsp_o.ack && !wb_req_i.we);
  c_evt: cover property ($rose(event_req_o[0]));
  c_od: cover property (open_drain_o[0]);
  c_tmr8: cover property (tsel_o[3].pwm == CCT_TMR8);
endmodule
bind cct_capture_top cct_capture_top_chk #(.SMALL_MEM(SMALL_MEM)) cct_capture_top_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .timer_one_i(timer_one_i), .timer_three_i(timer_three_i), .timer_five_i(timer_five_i),
  .timer_async_i(timer_async_i), .pin_i(pin_i), .open_drain_o(open_drain_o),
  .event_req_o(event_req_o), .tsel_o(tsel_o));

/* cct_pin_src.sv */
// cct_pin_src.sv: external signal source on the seven capture pins
// assumes: tasks are entered just after a rising clk_i edge
`timescale 1ns/1ns
module cct_pin_src (
  // clock
  input  wire logic  clk_i,
  // pins
  output logic [6:0] pin_o
);
  initial pin_o = 7'h00;
  // ----------------------------------------------------------------
  // level changes
  // ----------------------------------------------------------------
  // eight-cycle hold outlasts synchroniser and capture path
  task automatic drive(input int ch, input logic lvl);
    pin_o[ch] <= lvl;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pulses(input int ch, input int n);
    repeat (n) begin
      drive(ch, 1'b1);
      drive(ch, 1'b0);
    end
  endtask
endmodule

/* test_cct_capture_top.sv */
// test_cct_capture_top.sv: self-checking bench for the capture block
// assumes: design, checker and pin source compiled before it
`timescale 1ns/1ns
`include "cct_cfg.svh"
module test_cct_capture_top;
  import cct_pkg::*;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  cct_wb_req_t     req = '0;
  cct_wb_rsp_t     rsp;
  logic [15:0]     t1 = 16'h0000;
  logic [15:0]     t5 = 16'h0000;
  logic [2:0]      t_async = 3'h0;
  logic [6:0]      pins;
  logic [6:0]      od;
  logic [6:0]      evt;
  cct_tsel_t [6:0] tsel;
  int              error_cnt = 0;
  int              checks_done = 0;
  localparam logic [7:0] FLG = `CCT_OFS_FLAG;
  always #20 clk_i = ~clk_i;
  cct_capture_top cct_capture_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_req_i(req), .wb_rsp_o(rsp),
    .timer_one_i(t1), .timer_three_i(~t1), .timer_five_i(t5), .timer_async_i(t_async),
    .pin_i(pins), .open_drain_o(od), .event_req_o(evt), .tsel_o(tsel));
  cct_pin_src cct_pin_src_inst (.clk_i(clk_i), .pin_o(pins));
  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic we, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    req <= '{adr: a, dat: {24'h0, d}, sel: 4'h1, we: we, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    chk("ack", 16'h0001, {15'h0, rsp.ack});
    q = rsp.dat[7:0];
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(a, 1'b0, 8'h00, q);
    chk(nm, {8'h0, e}, {8'h0, q});
  endtask
  task automatic cap_chk(input int ch, input logic [15:0] e);
    logic [7:0] lo;
    logic [7:0] hi;
    xfer(8'(8'h24 + 16 * ch), 1'b0, 8'h00, lo);
    xfer(8'(8'h28 + 16 * ch), 1'b0, 8'h00, hi);
    chk("capture", e, {hi, lo});
  endtask
  function automatic logic [3:0] ets(input int k, input int c);
    cct_cc_tmr_t  cc;
    cct_pwm_tmr_t pw;
    cc = (c == 0) ? CCT_TIMER_ONE : (k == 0 ? CCT_TIMER_THREE : CCT_TIMER_FIVE);
    pw = (k == 2 || k == 6) ? CCT_TMR2 : cct_pwm_tmr_t'(c);
    return {cc, pw};
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++) rd_chk("reg_reset", 8'(i * 4), 8'h00);
    cap_chk(0, 16'h0000);
    wr(8'h14, 8'hff);
    rd_chk("unmapped", 8'h14, 8'h00);
  endtask
  task automatic t_tsel;
    logic [7:0] v;
    // reserved code 11 kept out of channels 4 and 8
    for (int i = 0; i < 4; i++) begin
      v = {2'(i), 1'b0, i[0], 1'b0, i[0], 2'(i % 3)};
      wr(`CCT_OFS_TSEL_LOW, v);
      rd_chk("tsel_low", `CCT_OFS_TSEL_LOW, v);
      v = {3'h0, i[0], 1'b0, i[0], 2'(i % 3)};
      wr(`CCT_OFS_TSEL_HIGH, v);
      rd_chk("tsel_high", `CCT_OFS_TSEL_HIGH, v);
      for (int k = 0; k < 7; k++)
        chk("tsel", {12'h0, ets(k, k == 3 ? i : (k % 4 == 0 ? i % 3 : i % 2))}, {12'h0, tsel[k]});
    end
  endtask
  task automatic t_modes;
    int n [4] = '{1, 1, 4, 16};
    for (int m = 0; m < 4; m++) begin
      wr(8'h20, 8'h00);
      wr(8'h20, 8'(4 + m));
      wr(FLG, 8'h00);
      t1 <= 16'hc3a0 + 16'(m);
      cct_pin_src_inst.pulses(0, n[m] - 1);
      rd_chk("flag_early", FLG, 8'h00);
      cct_pin_src_inst.drive(0, 1'b1);
      rd_chk("flag_rise", FLG, m == 0 ? 8'h00 : 8'h02);
      cct_pin_src_inst.drive(0, 1'b0);
      rd_chk("flag_fall", FLG, 8'h02);
      cap_chk(0, 16'hc3a0 + 16'(m));
    end
    wr(8'h24, 8'ha5);
    wr(8'h28, 8'h5a);
    cap_chk(0, 16'h5aa5);
  endtask
  task automatic t_sel_async;
    wr(`CCT_OFS_TSEL_LOW, 8'h05);
    wr(8'h30, 8'h05);
    t5 <= 16'h8e71;
    cct_pin_src_inst.pulses(1, 1);
    t5 <= 16'h17e8;
    cct_pin_src_inst.pulses(1, 1);
    cap_chk(1, 16'h17e8);
    wr(FLG, 8'h00);
    t_async <= 3'h4;
    t5 <= 16'h5555;
    cct_pin_src_inst.pulses(1, 1);
    cap_chk(1, 16'h17e8);
    rd_chk("flag_async", FLG, 8'h00);
    t_async <= 3'h0;
  endtask
  task automatic t_presc;
    wr(8'h20, 8'h06);
    cct_pin_src_inst.pulses(0, 2);
    wr(8'h20, 8'h00);
    wr(8'h20, 8'h06);
    wr(FLG, 8'h00);
    cct_pin_src_inst.pulses(0, 3);
    rd_chk("presc_clr", FLG, 8'h00);
    cct_pin_src_inst.pulses(0, 1);
    rd_chk("presc_fire", FLG, 8'h02);
    wr(8'h20, 8'h07);
    cct_pin_src_inst.pulses(0, 2);
    wr(8'h20, 8'h06);
    wr(FLG, 8'h00);
    cct_pin_src_inst.pulses(0, 1);
    rd_chk("presc_kept", FLG, 8'h00);
    cct_pin_src_inst.pulses(0, 1);
    rd_chk("presc_part", FLG, 8'h02);
    cap_chk(0, 16'h3c5c);
  endtask
  task automatic t_outputs;
    wr(`CCT_OFS_ENABLE, 8'h02);
    repeat (2) @(posedge clk_i);
    chk("event_req", 16'h0001, {9'h0, evt});
    wr(FLG, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("event_clr", 16'h0000, {9'h0, evt});
    wr(`CCT_OFS_OPEN_DRAIN, 8'h02);
    wr(8'h20, 8'h02);
    repeat (2) @(posedge clk_i);
    chk("od_out", 16'h0001, {9'h0, od});
    wr(8'h20, 8'h05);
    repeat (2) @(posedge clk_i);
    chk("od_cap", 16'h0000, {9'h0, od});
  endtask
  task automatic final_report;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_tsel;
    t_modes;
    t_sel_async;
    t_presc;
    t_outputs;
    final_report;
  end
  // hang guard, far past the run
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    final_report;
  end
endmodule
